// >>> user_three_timing_output_pkg.sv
// Shared constants, register map and carrier types for the user-three timing combiner
package user_three_timing_output_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int AXI_ADDR_W = 12;
	localparam int AXI_DATA_W = 32;
	localparam int IDX_W = 7;
	localparam int IDX_LSB = 2;
	localparam int REG_W = 16;

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_H_START = 7'h61;
	localparam logic [IDX_W-1:0] IDX_H_STOP = 7'h62;
	localparam logic [IDX_W-1:0] IDX_V_START = 7'h63;
	localparam logic [IDX_W-1:0] IDX_V_END = 7'h64;
	localparam logic [IDX_W-1:0] IDX_CTRL = 7'h65;
	localparam logic [IDX_W-1:0] IDX_STATUS = 7'h70;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam logic [REG_W-1:0] H_PIX_MASK = 16'hffff;
	localparam logic [REG_W-1:0] V_LINE_MASK = 16'h7fff;
	localparam logic [REG_W-1:0] CTRL_MASK = 16'h000f;
	localparam logic [REG_W-1:0] H_START_RESET = 16'h0000;
	localparam logic [REG_W-1:0] H_STOP_RESET = 16'h0000;
	localparam logic [REG_W-1:0] V_START_RESET = 16'h0000;
	localparam logic [REG_W-1:0] V_END_RESET = 16'h0000;
	localparam logic [REG_W-1:0] CTRL_RESET = 16'h0008;
	localparam int CTRL_POL_BIT = 3;
	localparam int CTRL_AND_BIT = 2;
	localparam int CTRL_OR_BIT = 1;
	localparam int CTRL_XOR_BIT = 0;
	localparam int LINE_W = 15;

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Counters from the main timing generator, same clock
	typedef struct packed {
		logic [REG_W-1:0] pixel;
		logic [LINE_W-1:0] frame_line;
		logic [LINE_W-1:0] field_line;
		logic interlaced;
	} timing_in_t;

	// State of the combiner; the two window flops sit in window_compare
	typedef struct packed {
		logic [REG_W-1:0] h_start;
		logic [REG_W-1:0] h_stop;
		logic [REG_W-1:0] v_start;
		logic [REG_W-1:0] v_end;
		logic [REG_W-1:0] ctrl;
		logic aw_held;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [AXI_DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [AXI_DATA_W-1:0] rdata;
		logic out;
	} core_state_t;

endpackage

// >>> window_compare.sv
// Half-open counter window: active while start <= count < stop, registered
`timescale 1ns/1ns
module window_compare #(
	parameter int W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] count,
	input wire logic [W-1:0] start,
	input wire logic [W-1:0] stop,
	output logic active
);

	typedef struct packed {
		logic active;
	} win_state_t;

	win_state_t st_r;
	win_state_t st_nxt;

	// ------------------------------------------------------------
	// Compare
	// ------------------------------------------------------------
	// Start not below stop gives an empty window rather than a wrapped one
	always_comb begin
		st_nxt = st_r;
		st_nxt.active = (count >= start) && (count < stop);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign active = st_r.active;

endmodule

// >>> user_timing_signal_three_combiner.sv
// User-three timing output: vertical and horizontal windows, combine operator, polarity, AXI4-Lite registers
//
// Summary of operation
// - Vertical window leading edge at line held in vertical start bits 14-0.
// - Vertical window trailing edge at line held in vertical end bits 14-0.
// - Interlaced output: vertical line values count within the odd field.
// - Polarity bit, reset one, makes output active low; cleared gives active high.
// - AND select drives output only while both windows are active.
// - With AND select set, OR and XOR selects are ignored.
// - OR select drives output while either window is active.
// - With OR select set, XOR select is ignored.
// - XOR select drives output while exactly one window is active.
// - Horizontal window starts at programmed pixel start count on every line.
// - Horizontal window ends at programmed pixel stop count on every line.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module user_timing_signal_three_combiner (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [user_three_timing_output_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [user_three_timing_output_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [user_three_timing_output_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [user_three_timing_output_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire user_three_timing_output_pkg::timing_in_t timing,
	output logic user_three_horizontal_window,
	output logic user_three_vertical_window,
	output logic user_three_timing_output
);

	user_three_timing_output_pkg::core_state_t st_r;
	user_three_timing_output_pkg::core_state_t st_nxt;

	logic h_win;
	logic v_win;
	logic [user_three_timing_output_pkg::REG_W-1:0] sel_line;
	logic combined;
	logic wr_fire;
	logic rd_fire;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic idx_ok(input logic [user_three_timing_output_pkg::AXI_ADDR_W-1:0] addr,
		input logic [user_three_timing_output_pkg::IDX_W-1:0] idx);
		idx_ok = (addr[user_three_timing_output_pkg::AXI_ADDR_W-1:user_three_timing_output_pkg::IDX_LSB] ==
			{{(user_three_timing_output_pkg::AXI_ADDR_W - user_three_timing_output_pkg::IDX_LSB - user_three_timing_output_pkg::IDX_W){1'b0}}, idx});
	endfunction

	function automatic logic is_writable(input logic [user_three_timing_output_pkg::AXI_ADDR_W-1:0] addr);
		is_writable = idx_ok(addr, user_three_timing_output_pkg::IDX_H_START) || idx_ok(addr, user_three_timing_output_pkg::IDX_H_STOP) ||
			idx_ok(addr, user_three_timing_output_pkg::IDX_V_START) || idx_ok(addr, user_three_timing_output_pkg::IDX_V_END) ||
			idx_ok(addr, user_three_timing_output_pkg::IDX_CTRL);
	endfunction

	// Byte lanes 0 and 1 carry the 16-bit register; reserved bits are stored as zero
	function automatic logic [user_three_timing_output_pkg::REG_W-1:0] merge(input logic [user_three_timing_output_pkg::REG_W-1:0] old,
		input logic [user_three_timing_output_pkg::AXI_DATA_W-1:0] data, input logic [3:0] strb,
		input logic [user_three_timing_output_pkg::REG_W-1:0] mask);
		logic [user_three_timing_output_pkg::REG_W-1:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = data[7:0];
		end
		if (strb[1]) begin
			v[15:8] = data[15:8];
		end
		merge = v & mask;
	endfunction

	// Operator priority: AND over OR over XOR; none selected gives inactive
	function automatic logic combine(input logic [user_three_timing_output_pkg::REG_W-1:0] ctrl, input logic h,
		input logic v);
		if (ctrl[user_three_timing_output_pkg::CTRL_AND_BIT]) begin
			combine = h & v;
		end else if (ctrl[user_three_timing_output_pkg::CTRL_OR_BIT]) begin
			combine = h | v;
		end else if (ctrl[user_three_timing_output_pkg::CTRL_XOR_BIT]) begin
			combine = h ^ v;
		end else begin
			combine = 1'b0;
		end
	endfunction

	// ------------------------------------------------------------
	// Windows
	// ------------------------------------------------------------
	// Field-relative count when interlaced, so the same values hit in each field
	assign sel_line = timing.interlaced ? {1'b0, timing.field_line} : {1'b0, timing.frame_line};

	window_compare #(
		.W(user_three_timing_output_pkg::REG_W)
	) u_h_window (
		.aclk(aclk),
		.aresetn(aresetn),
		.count(timing.pixel),
		.start(st_r.h_start),
		.stop(st_r.h_stop),
		.active(h_win)
	);

	window_compare #(
		.W(user_three_timing_output_pkg::REG_W)
	) u_v_window (
		.aclk(aclk),
		.aresetn(aresetn),
		.count(sel_line),
		.start(st_r.v_start),
		.stop(st_r.v_end),
		.active(v_win)
	);

	assign combined = combine(st_r.ctrl, h_win, v_win);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	assign wr_fire = st_r.aw_held && st_r.w_held && !st_r.bvalid;
	assign rd_fire = s_axi_arvalid && !st_r.rvalid;

	always_comb begin
		st_nxt = st_r;
		// Polarity applied last; one register stage after the windows
		st_nxt.out = st_r.ctrl[user_three_timing_output_pkg::CTRL_POL_BIT] ? ~combined : combined;
		if (s_axi_awvalid && !st_r.aw_held && !st_r.bvalid) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_r.w_held && !st_r.bvalid) begin
			st_nxt.w_held = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = is_writable(st_r.aw_addr) ? user_three_timing_output_pkg::RESP_OKAY : user_three_timing_output_pkg::RESP_SLVERR;
			if (idx_ok(st_r.aw_addr, user_three_timing_output_pkg::IDX_H_START)) begin
				st_nxt.h_start = merge(st_r.h_start, st_r.w_data, st_r.w_strb, user_three_timing_output_pkg::H_PIX_MASK);
			end
			if (idx_ok(st_r.aw_addr, user_three_timing_output_pkg::IDX_H_STOP)) begin
				st_nxt.h_stop = merge(st_r.h_stop, st_r.w_data, st_r.w_strb, user_three_timing_output_pkg::H_PIX_MASK);
			end
			if (idx_ok(st_r.aw_addr, user_three_timing_output_pkg::IDX_V_START)) begin
				st_nxt.v_start = merge(st_r.v_start, st_r.w_data, st_r.w_strb, user_three_timing_output_pkg::V_LINE_MASK);
			end
			if (idx_ok(st_r.aw_addr, user_three_timing_output_pkg::IDX_V_END)) begin
				st_nxt.v_end = merge(st_r.v_end, st_r.w_data, st_r.w_strb, user_three_timing_output_pkg::V_LINE_MASK);
			end
			if (idx_ok(st_r.aw_addr, user_three_timing_output_pkg::IDX_CTRL)) begin
				st_nxt.ctrl = merge(st_r.ctrl, st_r.w_data, st_r.w_strb, user_three_timing_output_pkg::CTRL_MASK);
			end
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (rd_fire) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = user_three_timing_output_pkg::RESP_OKAY;
			st_nxt.rdata = '0;
			if (idx_ok(s_axi_araddr, user_three_timing_output_pkg::IDX_H_START)) begin
				st_nxt.rdata[user_three_timing_output_pkg::REG_W-1:0] = st_r.h_start;
			end else if (idx_ok(s_axi_araddr, user_three_timing_output_pkg::IDX_H_STOP)) begin
				st_nxt.rdata[user_three_timing_output_pkg::REG_W-1:0] = st_r.h_stop;
			end else if (idx_ok(s_axi_araddr, user_three_timing_output_pkg::IDX_V_START)) begin
				st_nxt.rdata[user_three_timing_output_pkg::REG_W-1:0] = st_r.v_start;
			end else if (idx_ok(s_axi_araddr, user_three_timing_output_pkg::IDX_V_END)) begin
				st_nxt.rdata[user_three_timing_output_pkg::REG_W-1:0] = st_r.v_end;
			end else if (idx_ok(s_axi_araddr, user_three_timing_output_pkg::IDX_CTRL)) begin
				st_nxt.rdata[user_three_timing_output_pkg::REG_W-1:0] = st_r.ctrl;
			end else if (idx_ok(s_axi_araddr, user_three_timing_output_pkg::IDX_STATUS)) begin
				// Live view: windows, combined level, pin level
				st_nxt.rdata[3:0] = {st_r.out, combined, v_win, h_win};
			end else begin
				st_nxt.rresp = user_three_timing_output_pkg::RESP_SLVERR;
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.h_start <= user_three_timing_output_pkg::H_START_RESET;
			st_r.h_stop <= user_three_timing_output_pkg::H_STOP_RESET;
			st_r.v_start <= user_three_timing_output_pkg::V_START_RESET;
			st_r.v_end <= user_three_timing_output_pkg::V_END_RESET;
			st_r.ctrl <= user_three_timing_output_pkg::CTRL_RESET;
			// Idle pin is the inactive level of the reset polarity
			st_r.out <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// No write is taken while a response waits; one write in flight keeps ordering simple
	assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
	assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign user_three_horizontal_window = h_win;
	assign user_three_vertical_window = v_win;
	assign user_three_timing_output = st_r.out;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_both_on;
		h_win && v_win;
	endsequence

	sequence s_one_on;
		h_win ^ v_win;
	endsequence

	property p_pol_reset;
		@(posedge aclk) !aresetn |=> st_r.ctrl[user_three_timing_output_pkg::CTRL_POL_BIT] && user_three_timing_output;
	endproperty
	a_pol_reset: assert property (p_pol_reset) else $error("polarity bit not one after reset");

	property p_pol_high;
		@(posedge aclk) disable iff (!aresetn)
			((!st_r.ctrl[user_three_timing_output_pkg::CTRL_POL_BIT] && st_r.ctrl[user_three_timing_output_pkg::CTRL_AND_BIT]) and s_both_on)
			|=> user_three_timing_output;
	endproperty
	a_pol_high: assert property (p_pol_high) else $error("active-high output not asserted");

	property p_and_on;
		@(posedge aclk) disable iff (!aresetn)
			((st_r.ctrl[user_three_timing_output_pkg::CTRL_AND_BIT]) and s_both_on)
			|=> user_three_timing_output == !$past(st_r.ctrl[user_three_timing_output_pkg::CTRL_POL_BIT]);
	endproperty
	a_and_on: assert property (p_and_on) else $error("and mode missed both windows");

	property p_and_masks;
		@(posedge aclk) disable iff (!aresetn)
			(st_r.ctrl[user_three_timing_output_pkg::CTRL_AND_BIT] && !(h_win && v_win))
			|=> user_three_timing_output == $past(st_r.ctrl[user_three_timing_output_pkg::CTRL_POL_BIT]);
	endproperty
	a_and_masks: assert property (p_and_masks) else $error("and mode asserted with one window");

	property p_or_mode;
		@(posedge aclk) disable iff (!aresetn)
			(!st_r.ctrl[user_three_timing_output_pkg::CTRL_AND_BIT] && st_r.ctrl[user_three_timing_output_pkg::CTRL_OR_BIT])
			|=> user_three_timing_output == ($past(h_win || v_win) ^ $past(st_r.ctrl[user_three_timing_output_pkg::CTRL_POL_BIT]));
	endproperty
	a_or_mode: assert property (p_or_mode) else $error("or mode wrong level");

	property p_xor_mode;
		@(posedge aclk) disable iff (!aresetn)
			((st_r.ctrl[2:0] == 3'h1) and s_one_on)
			|=> user_three_timing_output == !$past(st_r.ctrl[user_three_timing_output_pkg::CTRL_POL_BIT]);
	endproperty
	a_xor_mode: assert property (p_xor_mode) else $error("xor mode missed single window");

	property p_none_idle;
		@(posedge aclk) disable iff (!aresetn)
			(st_r.ctrl[2:0] == 3'h0)
			|=> user_three_timing_output == $past(st_r.ctrl[user_three_timing_output_pkg::CTRL_POL_BIT]);
	endproperty
	a_none_idle: assert property (p_none_idle) else $error("output active with no operator");

	property p_v_window;
		@(posedge aclk) disable iff (!aresetn)
			!timing.interlaced ##0 ({1'b0, timing.frame_line} >= st_r.v_start) ##0
			({1'b0, timing.frame_line} < st_r.v_end) |=> v_win;
	endproperty
	a_v_window: assert property (p_v_window) else $error("vertical window not active in range");

	property p_v_interlace;
		@(posedge aclk) disable iff (!aresetn)
			(timing.interlaced && ({1'b0, timing.field_line} < st_r.v_start))
			|=> !v_win;
	endproperty
	a_v_interlace: assert property (p_v_interlace) else $error("interlaced window before start line");

	property p_h_window;
		@(posedge aclk) disable iff (!aresetn)
			(timing.pixel >= st_r.h_start && timing.pixel < st_r.h_stop) |=> h_win;
	endproperty
	a_h_window: assert property (p_h_window) else $error("horizontal window not active in range");

	property p_h_end;
		@(posedge aclk) disable iff (!aresetn)
			(timing.pixel >= st_r.h_stop) |=> !h_win;
	endproperty
	a_h_end: assert property (p_h_end) else $error("horizontal window past stop count");

	property p_write_answer;
		@(posedge aclk) disable iff (!aresetn)
			(s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write response late");

endmodule

// >>> user_three_timing_output_timing_src.sv
// Stand-in for the main timing generator that feeds pixel and line counts
`timescale 1ns/1ns
module user_three_timing_output_timing_src #(
	parameter int FIELD_LINES = 563
) (
	input wire logic aclk,
	input wire logic [15:0] pix,
	input wire logic [14:0] line,
	input wire logic ilace,
	output user_three_timing_output_pkg::timing_in_t timing
);
	// Counts leave through flops like the real generator, one edge behind the request
	always_ff @(posedge aclk) begin
		timing.pixel <= pix;
		timing.frame_line <= line;
		// Second field restarts its count, so odd-field line values hold in both fields
		timing.field_line <= (ilace && line >= 15'(FIELD_LINES)) ? line - 15'(FIELD_LINES) : line;
		timing.interlaced <= ilace;
	end
endmodule

// >>> user_timing_signal_three_combiner_tb.sv
// Self-checking bench for the user-three timing combiner
`timescale 1ns/1ns
module user_timing_signal_three_combiner_tb;
	localparam int FL = 563;
	localparam logic [1:0] OK = user_three_timing_output_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = user_three_timing_output_pkg::RESP_SLVERR;
	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] pix;
		logic [14:0] line;
		logic [2:0] exp;
	} row_t;
	logic aclk, aresetn, ilace;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] pix;
	logic [14:0] line;
	logic hw, vw, uo;
	user_three_timing_output_pkg::timing_in_t timing;
	int error_cnt, total_checks;
	// Windows: pixels 10..19, lines 5..7; expected bits are {h, v, out}
	row_t rows [17] = '{
		{16'h0004, 16'h000f, 15'h0006, 3'h7},
		{16'h0004, 16'h000f, 15'h0002, 3'h4},
		{16'h0007, 16'h0002, 15'h0006, 3'h2},
		{16'h0006, 16'h000f, 15'h0002, 3'h4},
		{16'h0002, 16'h000f, 15'h0002, 3'h5},
		{16'h0002, 16'h0002, 15'h0006, 3'h3},
		{16'h0002, 16'h0014, 15'h0008, 3'h0},
		{16'h0003, 16'h000f, 15'h0006, 3'h7},
		{16'h0001, 16'h000f, 15'h0006, 3'h6},
		{16'h0001, 16'h0002, 15'h0006, 3'h3},
		{16'h0001, 16'h000a, 15'h0005, 3'h6},
		{16'h0001, 16'h0013, 15'h0008, 3'h5},
		{16'h0004, 16'h000a, 15'h0004, 3'h4},
		{16'h0000, 16'h000f, 15'h0006, 3'h6},
		{16'h0008, 16'h000f, 15'h0006, 3'h7},
		{16'h000c, 16'h000f, 15'h0006, 3'h6},
		{16'h000c, 16'h0009, 15'h0002, 3'h1}
	};

	user_three_timing_output_timing_src #(.FIELD_LINES(FL)) i_src (.aclk(aclk), .pix(pix), .line(line), .ilace(ilace), .timing(timing));

	user_timing_signal_three_combiner i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .timing(timing), .user_three_horizontal_window(hw),
		.user_three_vertical_window(vw), .user_three_timing_output(uo)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [11:0] adr(input logic [6:0] i);
		return {3'h0, i, 2'h0};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Sampling at the falling edge: the slave answers from flops, so values there equal the next rising edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		tb = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			if (tb) chk({30'h0, s_axi_bresp}, {30'h0, er});
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tr;
		tr = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!tr) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			if (tr) chk(s_axi_rdata, ed);
			if (tr) chk({30'h0, s_axi_rresp}, {30'h0, er});
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
	endtask

	// Counts pass the source flop, the window flop and the output flop before they show
	task automatic settle(input logic [15:0] p, input logic [14:0] l, input logic il);
		@(posedge aclk);
		pix <= p;
		line <= l;
		ilace <= il;
		repeat (5) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and sequence
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		#100000;
		error_cnt++;
		stop_test;
	end

	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ilace} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, pix, line} = '0;
		error_cnt = 0;
		total_checks = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({31'h0, uo}, 32'h1);
		rd(adr(user_three_timing_output_pkg::IDX_V_START), 32'h0, OK);
		rd(adr(user_three_timing_output_pkg::IDX_V_END), 32'h0, OK);
		rd(adr(user_three_timing_output_pkg::IDX_CTRL), 32'h8, OK);
		rd(12'h000, 32'h0, ERR);
		wr(12'h000, 32'h1, ERR);
		wr(adr(user_three_timing_output_pkg::IDX_STATUS), 32'h0, ERR);
		$display("test reset done");
		// Start below stop, bit 15 clear, end within the field
		wr(adr(user_three_timing_output_pkg::IDX_H_START), 32'h000a, OK);
		wr(adr(user_three_timing_output_pkg::IDX_H_STOP), 32'h0014, OK);
		wr(adr(user_three_timing_output_pkg::IDX_V_START), 32'h0005, OK);
		wr(adr(user_three_timing_output_pkg::IDX_V_END), 32'h0008, OK);
		rd(adr(user_three_timing_output_pkg::IDX_V_START), 32'h5, OK);
		rd(adr(user_three_timing_output_pkg::IDX_V_END), 32'h8, OK);
		foreach (rows[i]) begin
			wr(adr(user_three_timing_output_pkg::IDX_CTRL), {16'h0, rows[i].ctrl}, OK);
			settle(rows[i].pix, rows[i].line, 1'b0);
			chk({29'h0, hw, vw, uo}, {29'h0, rows[i].exp});
			$display("test row %0d done", i);
		end
		// Line in the second field: odd-field values apply only when interlaced
		wr(adr(user_three_timing_output_pkg::IDX_CTRL), 32'h2, OK);
		settle(16'h0002, 15'(FL + 6), 1'b1);
		chk({30'h0, vw, uo}, 32'h3);
		// Status bits {pin, combined, v, h} while only the vertical window is on
		rd(adr(user_three_timing_output_pkg::IDX_STATUS), 32'he, OK);
		// Field line below the start value keeps the window shut
		settle(16'h0002, 15'(FL + 2), 1'b1);
		chk({30'h0, vw, uo}, 32'h0);
		settle(16'h0002, 15'(FL + 6), 1'b0);
		chk({30'h0, vw, uo}, 32'h0);
		$display("test interlace done");
		// Reset in mid-run must restore register defaults and the idle pin
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({31'h0, uo}, 32'h1);
		rd(adr(user_three_timing_output_pkg::IDX_CTRL), 32'h8, OK);
		rd(adr(user_three_timing_output_pkg::IDX_V_END), 32'h0, OK);
		$display("test mid reset done");
		stop_test;
	end
endmodule
